// [common/axis_mon_pkg.sv]
// constants, types and helpers of the axis limit and referencing monitor
// Notes on behaviour
// - hardware limit bit halts all axes, flags error
// - jog toward approached limit ignored afterwards
// - limit checks idle until axis is referenced
// - auto block crossing limit is refused, error
// - jog hits limit: decelerate, partners too, interrupt
// - second limit pair per direction replaces first
// - first plus limit defaults to 100000000
// - rotary axes skip software limit checks
// - working area enable per direction, default off
// - reference start by approach direction, all axes
// - program start blocked until required axes referenced
// - per axis referencing required flag, default yes
// - module reset aborts referencing, reports error
// - referenced status output per axis
package axis_mon_pkg;
    localparam int NUM_AXES = 4;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] MASK_OFS = 12'h008;
    localparam logic [11:0] STATE_OFS = 12'h00C;
    localparam logic [11:0] AXIS_BASE = 12'h080;
    localparam int W_SL1P = 0;
    localparam int W_SL1M = 1;
    localparam int W_SL2P = 2;
    localparam int W_SL2M = 3;
    localparam int W_WAP = 4;
    localparam int W_WAM = 5;
    localparam int W_CFG = 6;
    localparam int W_HOST = 7;
    localparam int CTRL_NOREF_BIT = 3;
    localparam int CTRL_RESET_BIT = 7;
    localparam int CFG_ROTARY = 0;
    localparam int CFG_WA_P = 1;
    localparam int CFG_WA_M = 2;
    localparam int CFG_REF_REQ = 3;
    localparam int CFG_APPR_M = 4;
    localparam int CFG_INTERP = 5;
    localparam int HOST_HWL_M = 0;
    localparam int HOST_HWL_P = 1;
    localparam int HOST_SL2_M = 2;
    localparam int HOST_SL2_P = 3;
    localparam int HOST_DIR_M = 6;
    localparam int HOST_DIR_P = 7;
    localparam int ST_HW_LIMIT = 0;
    localparam int ST_SW_LIMIT = 1;
    localparam int ST_BLOCK_REF = 2;
    localparam int ST_REF_ABORT = 3;
    localparam int ST_START_REF = 4;
    localparam int ST_W = 5;
    localparam logic [31:0] LIM_P_RST = 32'h05F5E100;
    localparam logic [31:0] LIM_M_RST = 32'hFA0A1F00;
    localparam logic [31:0] CFG_RST = 32'h00000008;
    localparam logic [31:0] HOST_RST = 32'h00000000;
    localparam logic [ST_W-1:0] MASK_RST = 5'h00;

    typedef enum logic [1:0] {MODE_JOG, MODE_INC, MODE_AUTO, MODE_REF} mode_t;

    function automatic logic past_limit(input logic signed [31:0] pos,
                                        input logic signed [31:0] lim,
                                        input logic plus);
        return plus ? (pos >= lim) : (pos <= lim);
    endfunction : past_limit

    function automatic logic [31:0] word_reset(input logic [2:0] w);
        unique case (w)
            3'h0, 3'h2, 3'h4: return LIM_P_RST;
            3'h1, 3'h3, 3'h5: return LIM_M_RST;
            3'h6: return CFG_RST;
            default: return HOST_RST;
        endcase
    endfunction : word_reset
endpackage : axis_mon_pkg

// [common/limit_chk_if.sv]
// signals between the monitor and one axis limit checker
`timescale 1ns/1ns
interface limit_chk_if;
    logic signed [31:0] pos, target;
    logic signed [31:0] lim_p1, lim_m1, lim_p2, lim_m2, wa_p, wa_m;
    logic [31:0] cfg;
    logic sel2_p, sel2_m, referenced;
    logic at_plus, at_minus, target_bad;
    modport chk (input pos, target, lim_p1, lim_m1, lim_p2, lim_m2, wa_p, wa_m,
                 input cfg, sel2_p, sel2_m, referenced,
                 output at_plus, at_minus, target_bad);
    modport own (output pos, target, lim_p1, lim_m1, lim_p2, lim_m2, wa_p, wa_m,
                 output cfg, sel2_p, sel2_m, referenced,
                 input at_plus, at_minus, target_bad);
endinterface : limit_chk_if

// [core/axis_limit_check.sv]
// per-axis comparison against software and working area limits
`timescale 1ns/1ns
module axis_limit_check (
    // limits in, results out
    limit_chk_if.chk lc
);
    import axis_mon_pkg::*;
    wire sw_on = lc.referenced & ~lc.cfg[CFG_ROTARY];
    wire wa_on_p = lc.referenced & lc.cfg[CFG_WA_P];
    wire wa_on_m = lc.referenced & lc.cfg[CFG_WA_M];
    // switching pairs takes effect in the same cycle
    wire signed [31:0] lim_p = lc.sel2_p ? lc.lim_p2 : lc.lim_p1;
    wire signed [31:0] lim_m = lc.sel2_m ? lc.lim_m2 : lc.lim_m1;
    wire pos_p = (sw_on & past_limit(lc.pos, lim_p, 1'b1))
               | (wa_on_p & past_limit(lc.pos, lc.wa_p, 1'b1));
    wire pos_m = (sw_on & past_limit(lc.pos, lim_m, 1'b0))
               | (wa_on_m & past_limit(lc.pos, lc.wa_m, 1'b0));
    // a target sitting exactly on a limit is still legal
    wire tgt_p = (sw_on & past_limit(lc.target, lim_p + 32'sd1, 1'b1))
               | (wa_on_p & past_limit(lc.target, lc.wa_p + 32'sd1, 1'b1));
    wire tgt_m = (sw_on & past_limit(lc.target, lim_m - 32'sd1, 1'b0))
               | (wa_on_m & past_limit(lc.target, lc.wa_m - 32'sd1, 1'b0));
    assign lc.at_plus = pos_p;
    assign lc.at_minus = pos_m;
    assign lc.target_bad = tgt_p | tgt_m;
endmodule : axis_limit_check

// [core/axis_limit_monitor.sv]
// axis limit supervision and referencing gate with ahb-lite registers
`timescale 1ns/1ns
module axis_limit_monitor (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // motion core side
    input wire logic [axis_mon_pkg::NUM_AXES-1:0][31:0] axis_pos_in,
    input wire logic [axis_mon_pkg::NUM_AXES-1:0][31:0] target_pos_in,
    input wire logic block_req_in,
    input wire logic prog_start_req_in,
    input wire logic [axis_mon_pkg::NUM_AXES-1:0] ref_done_in,
    // stop and motion permits
    output logic halt_all_out,
    output logic [axis_mon_pkg::NUM_AXES-1:0] decel_out,
    output logic [axis_mon_pkg::NUM_AXES-1:0] jog_plus_out,
    output logic [axis_mon_pkg::NUM_AXES-1:0] jog_minus_out,
    output logic prog_interrupt_out,
    output logic block_go_out,
    output logic block_refused_out,
    output logic prog_start_out,
    // referencing
    output logic [axis_mon_pkg::NUM_AXES-1:0] ref_run_out,
    output logic [axis_mon_pkg::NUM_AXES-1:0] referenced_out,
    // interrupt
    output logic irq_out
);
    import axis_mon_pkg::*;
    localparam int N = NUM_AXES;

    logic [31:0] axis_regs [0:N*8-1];
    mode_t mode;
    logic noref;
    logic [ST_W-1:0] status, mask;
    logic dp_act, dp_write;
    logic [11:0] dp_addr;
    logic [N-1:0] blk_plus, blk_minus, stop, ref_go_d;
    logic [31:0] rd_val;

    // bus decode; every transfer takes one wait state so a read
    // always sees the write just before it
    wire addr_ok = hsel_in & htrans_in[1] & hready_in;
    wire wr_now = dp_act & dp_write;
    wire in_axis = dp_addr[11:7] == AXIS_BASE[11:7];
    wire [4:0] widx = dp_addr[6:2];
    wire wr_ctrl = wr_now & (dp_addr == CTRL_OFS);
    wire wr_stat = wr_now & (dp_addr == STAT_OFS);
    wire wr_mask = wr_now & (dp_addr == MASK_OFS);
    wire wr_axis = wr_now & in_axis;
    wire mod_reset = wr_ctrl & hwdata_in[CTRL_RESET_BIT];

    // per-axis host bits and checker results
    logic [N-1:0] hw_p, hw_m, dir_p, dir_m, appr_m, need_ref, interp;
    logic [N-1:0] at_p, at_m, tgt_bad;
    limit_chk_if lc [N] ();

    for (genvar i = 0; i < N; i++) begin : g_ax
        wire [31:0] host = axis_regs[i*8+W_HOST];
        wire [31:0] cfg = axis_regs[i*8+W_CFG];
        assign hw_p[i] = host[HOST_HWL_P];
        assign hw_m[i] = host[HOST_HWL_M];
        assign dir_p[i] = host[HOST_DIR_P];
        assign dir_m[i] = host[HOST_DIR_M];
        assign appr_m[i] = cfg[CFG_APPR_M];
        assign need_ref[i] = cfg[CFG_REF_REQ];
        assign interp[i] = cfg[CFG_INTERP];
        assign lc[i].pos = axis_pos_in[i];
        assign lc[i].target = target_pos_in[i];
        assign lc[i].lim_p1 = axis_regs[i*8+W_SL1P];
        assign lc[i].lim_m1 = axis_regs[i*8+W_SL1M];
        assign lc[i].lim_p2 = axis_regs[i*8+W_SL2P];
        assign lc[i].lim_m2 = axis_regs[i*8+W_SL2M];
        assign lc[i].wa_p = axis_regs[i*8+W_WAP];
        assign lc[i].wa_m = axis_regs[i*8+W_WAM];
        assign lc[i].cfg = cfg;
        assign lc[i].sel2_p = host[HOST_SL2_P];
        assign lc[i].sel2_m = host[HOST_SL2_M];
        assign lc[i].referenced = referenced_out[i];
        assign at_p[i] = lc[i].at_plus;
        assign at_m[i] = lc[i].at_minus;
        assign tgt_bad[i] = lc[i].target_bad;
        axis_limit_check u_chk (
            .lc(lc[i])
        );
    end

    // limit responses; every latch is set-wins over module reset
    wire [N-1:0] rst_v = {N{mod_reset}};
    wire hw_any = |(hw_p | hw_m);
    wire jog_mode = (mode == MODE_JOG) | (mode == MODE_INC);
    wire [N-1:0] sw_hit_p = {N{jog_mode}} & dir_p & at_p;
    wire [N-1:0] sw_hit_m = {N{jog_mode}} & dir_m & at_m;
    wire next_halt = (halt_all_out & ~mod_reset) | hw_any;
    wire [N-1:0] next_blk_plus = (blk_plus & ~rst_v) | hw_p | sw_hit_p;
    wire [N-1:0] next_blk_minus = (blk_minus & ~rst_v) | hw_m | sw_hit_m;
    wire [N-1:0] next_stop = (stop & ~rst_v) | sw_hit_p | sw_hit_m;
    // partners in the interpolation group follow the stopping axis
    wire grp_hit = |(next_stop & interp);
    wire [N-1:0] next_decel = next_stop | (interp & {N{grp_hit}});
    // only a switch still pressed stops all jogging; a latched halt must still let
    // the operator jog away from the approached limit
    wire [N-1:0] next_jog_p = {N{jog_mode & ~hw_any}} & dir_p & ~next_blk_plus;
    wire [N-1:0] next_jog_m = {N{jog_mode & ~hw_any}} & dir_m & ~next_blk_minus;

    // automatic block and program start
    wire auto_mode = mode == MODE_AUTO;
    wire blk_bad = |tgt_bad;
    wire next_block_go = block_req_in & auto_mode & ~blk_bad & ~next_halt;
    wire next_block_ref = block_req_in & auto_mode & blk_bad;
    wire start_ok = noref | (&(referenced_out | ~need_ref));
    wire next_start = prog_start_req_in & start_ok;
    wire start_ref = prog_start_req_in & ~start_ok;

    // referencing: start on the edge of the approach direction key
    wire [N-1:0] ref_go = {N{mode == MODE_REF}}
                        & ((appr_m & dir_m) | (~appr_m & dir_p));
    wire [N-1:0] ref_start = ref_go & ~ref_go_d & ~ref_run_out & ~rst_v;
    wire [N-1:0] next_ref_run = (ref_run_out | ref_start) & ~ref_done_in & ~rst_v;
    wire [N-1:0] next_refd = (referenced_out & ~ref_start)
                           | (ref_run_out & ref_done_in & ~rst_v);
    wire ref_abort = mod_reset & (|ref_run_out);

    wire [ST_W-1:0] set_ev = {start_ref, ref_abort, next_block_ref,
                              |(sw_hit_p | sw_hit_m), hw_any};
    wire [ST_W-1:0] clr_ev = {ST_W{wr_stat}} & hwdata_in[ST_W-1:0];
    wire [ST_W-1:0] next_status = (status & ~clr_ev) | set_ev;

    always_comb begin
        rd_val = 32'h00000000;
        if (in_axis) begin
            rd_val = axis_regs[widx];
        end else if (dp_addr == CTRL_OFS) begin
            rd_val = {28'h0000000, noref, 1'b0, mode};
        end else if (dp_addr == STAT_OFS) begin
            rd_val = {27'h0000000, status};
        end else if (dp_addr == MASK_OFS) begin
            rd_val = {27'h0000000, mask};
        end else if (dp_addr == STATE_OFS) begin
            rd_val = {16'h0000, ref_run_out, referenced_out, blk_minus, blk_plus};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dp_act <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
            hreadyout_out <= 1'b1;
            hrdata_out <= 32'h00000000;
            hresp_out <= 1'b0;
        end else if (addr_ok) begin
            dp_act <= 1'b1;
            dp_write <= hwrite_in;
            dp_addr <= {haddr_in[11:2], 2'b00};
            hreadyout_out <= 1'b0;
        end else if (dp_act) begin
            dp_act <= 1'b0;
            hreadyout_out <= 1'b1;
            hrdata_out <= dp_write ? 32'h00000000 : rd_val;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int k = 0; k < N*8; k++) begin
                axis_regs[k] <= word_reset(k[2:0]);
            end
        end else if (wr_axis) begin
            axis_regs[widx] <= hwdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode <= MODE_JOG;
            noref <= 1'b0;
            mask <= MASK_RST;
        end else begin
            if (wr_ctrl) begin
                mode <= mode_t'(hwdata_in[1:0]);
                noref <= hwdata_in[CTRL_NOREF_BIT];
            end
            if (wr_mask) begin
                mask <= hwdata_in[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status <= '0;
            irq_out <= 1'b0;
            halt_all_out <= 1'b0;
            blk_plus <= '0;
            blk_minus <= '0;
            stop <= '0;
            decel_out <= '0;
            jog_plus_out <= '0;
            jog_minus_out <= '0;
            prog_interrupt_out <= 1'b0;
        end else begin
            status <= next_status;
            irq_out <= |(next_status & mask);
            halt_all_out <= next_halt;
            blk_plus <= next_blk_plus;
            blk_minus <= next_blk_minus;
            stop <= next_stop;
            decel_out <= next_decel;
            jog_plus_out <= next_jog_p;
            jog_minus_out <= next_jog_m;
            prog_interrupt_out <= |next_stop;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            block_go_out <= 1'b0;
            block_refused_out <= 1'b0;
            prog_start_out <= 1'b0;
            ref_go_d <= '0;
            ref_run_out <= '0;
            referenced_out <= '0;
        end else begin
            block_go_out <= next_block_go;
            block_refused_out <= next_block_ref;
            prog_start_out <= next_start;
            ref_go_d <= ref_go;
            ref_run_out <= next_ref_run;
            referenced_out <= next_refd;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_bad_block;
        block_req_in && auto_mode && blk_bad;
    endsequence
    sequence s_refused_seen;
        block_refused_out && !block_go_out && status[ST_BLOCK_REF];
    endsequence
    sequence s_abort;
        mod_reset && (|ref_run_out);
    endsequence

    chk_hw_limit_halt: assert property (
        hw_any |=> halt_all_out && jog_plus_out == '0 && status[ST_HW_LIMIT])
        else $error("hardware limit did not halt all axes");
    chk_jog_blocked: assert property (
        (blk_plus != '0) && !mod_reset |=> (jog_plus_out & $past(blk_plus)) == '0)
        else $error("jog toward approached limit was passed");
    chk_unref_quiet: assert property (
        ((at_p | at_m | tgt_bad) & ~referenced_out) == '0)
        else $error("limit check active on unreferenced axis");
    chk_block_refuse: assert property (
        s_bad_block |=> s_refused_seen)
        else $error("block crossing a limit was not refused");
    chk_jog_decel: assert property (
        sw_hit_p[2] |=> decel_out[2] && prog_interrupt_out
                        && (decel_out[0] || !(interp[0] && interp[2])) ##1 decel_out[2])
        else $error("jog limit hit did not decelerate");
    chk_second_pair: assert property (
        (referenced_out[1] && !lc[1].cfg[CFG_ROTARY] && lc[1].sel2_p
         && $signed(axis_pos_in[1]) >= $signed(axis_regs[8+W_SL2P])) |-> at_p[1])
        else $error("second plus limit not in force");
    chk_sl1_default: assert property (
        $rose(rst_b_in) |-> axis_regs[W_SL1P] == LIM_P_RST)
        else $error("first plus limit default wrong");
    chk_rotary_skip: assert property (
        (lc[0].cfg[CFG_ROTARY] && !lc[0].cfg[CFG_WA_P]) |-> !at_p[0])
        else $error("rotary axis checked against software limit");
    chk_wa_plus: assert property (
        (referenced_out[0] && lc[0].cfg[CFG_ROTARY] && lc[0].cfg[CFG_WA_P]
         && $signed(axis_pos_in[0]) >= $signed(axis_regs[W_WAP])) |-> at_p[0])
        else $error("working area plus limit ignored");
    chk_ref_start: assert property (
        ref_start[0] |=> ref_run_out[0] && !referenced_out[0])
        else $error("reference approach did not start");
    chk_start_gate: assert property (
        (prog_start_req_in && !noref && ((need_ref & ~referenced_out) != '0))
        |=> !prog_start_out && status[ST_START_REF])
        else $error("program start allowed with unreferenced axis");
    chk_reset_abort: assert property (
        s_abort |=> ref_run_out == '0 && (referenced_out & $past(ref_run_out)) == '0
                    && status[ST_REF_ABORT])
        else $error("module reset did not abort referencing");
    chk_ref_status: assert property (
        (ref_run_out[1] && ref_done_in[1] && !mod_reset) |=> referenced_out[1])
        else $error("referenced status not set");
    chk_error_latch: assert property (
        (halt_all_out && !mod_reset) |=> halt_all_out)
        else $error("limit error dropped without reset");
endmodule : axis_limit_monitor

// [tb/host_bus_model.sv]
// ahb-lite master model standing in for the host controller
`timescale 1ns/1ns
module host_bus_model (
    // clock
    input wire logic clk_in,
    // answer from the slave
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    // request to the slave
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end

    // entered just after a rising edge; waits on hready with no assumed latency
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        hsel_out <= 1'b1;
        haddr_out <= addr;
        htrans_out <= 2'h2;
        hwrite_out <= wr;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= wdata;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
    endtask : xfer
endmodule : host_bus_model

// [tb/axis_limit_monitor_tb.sv]
// self-checking bench of the axis limit and referencing monitor
`timescale 1ns/1ns
module axis_limit_monitor_tb;
    import axis_mon_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel, hwrite, hready, hresp, block_req, prog_req, halt, prog_int, blk_go, blk_ref;
    logic prog_go, irq;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [NUM_AXES-1:0][31:0] pos, tgt;
    logic [NUM_AXES-1:0] ref_done, decel, jog_p, jog_m, ref_run, refd;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 sys_clk = ~sys_clk;

    axis_limit_monitor uut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .axis_pos_in(pos), .target_pos_in(tgt), .block_req_in(block_req),
        .prog_start_req_in(prog_req), .ref_done_in(ref_done), .halt_all_out(halt),
        .decel_out(decel), .jog_plus_out(jog_p), .jog_minus_out(jog_m),
        .prog_interrupt_out(prog_int), .block_go_out(blk_go), .block_refused_out(blk_ref),
        .prog_start_out(prog_go), .ref_run_out(ref_run), .referenced_out(refd), .irq_out(irq));

    host_bus_model host (.clk_in(sys_clk), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // a hang costs at most this many cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] ax(input int a, input int w);
        return 32'(AXIS_BASE) + 32'(a * 32 + w * 4);
    endfunction : ax

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        host.xfer(1'b1, addr, data, unused);
    endtask : wr

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input string what);
        host.xfer(1'b0, addr, 32'h0, rdat);
        check(rdat, exp, what);
    endtask : rd_chk

    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask : settle

    // one-cycle pulses on the motion core requests
    task automatic pulse(input logic blk, input logic prog, input logic [NUM_AXES-1:0] done);
        @(posedge sys_clk);
        block_req <= blk;
        prog_req <= prog;
        ref_done <= done;
        @(posedge sys_clk);
        block_req <= 1'b0;
        prog_req <= 1'b0;
        ref_done <= '0;
        #1;
    endtask : pulse

    initial begin
        pos = '0;
        tgt = '0;
        block_req = 1'b0;
        prog_req = 1'b0;
        ref_done = '0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < NUM_AXES; a++) begin
            for (int w = 0; w < 8; w++) begin
                rd_chk(ax(a, w), w == W_HOST ? HOST_RST : w == W_CFG ? CFG_RST :
                       w[0] ? LIM_M_RST : LIM_P_RST, "reset word");
            end
        end
        rd_chk(32'h040, 32'h0, "unmapped read");
        rd_chk(32'(STAT_OFS), 32'h0, "status after reset");
        check({31'h0, hresp}, 32'h0, "bus response");
        $display("test done: reset values");
        pulse(1'b0, 1'b1, '0);
        check({31'h0, prog_go}, 32'h0, "start without referencing");
        rd_chk(32'(STAT_OFS), 32'h1 << ST_START_REF, "start refused flag");
        wr(32'(CTRL_OFS), 32'h1 << CTRL_NOREF_BIT);
        pulse(1'b0, 1'b1, '0);
        check({31'h0, prog_go}, 32'h1, "start with override");
        wr(32'(STAT_OFS), 32'h1F);
        wr(32'(CTRL_OFS), 32'h3);
        wr(ax(1, W_CFG), 32'h18);
        for (int a = 0; a < NUM_AXES; a++) begin
            wr(ax(a, W_HOST), a == 1 ? 32'h40 : 32'h80);
        end
        settle();
        check({28'h0, ref_run}, 32'hF, "all axes referencing");
        check({28'h0, refd}, 32'h0, "none referenced yet");
        pulse(1'b0, 1'b0, 4'h7);
        check({28'h0, refd}, 32'h7, "referenced status");
        check({28'h0, ref_run}, 32'h8, "one still running");
        wr(32'(CTRL_OFS), 32'h83);
        settle();
        check({28'h0, ref_run}, 32'h0, "referencing aborted");
        check({28'h0, refd}, 32'h7, "unfinished axis unreferenced");
        rd_chk(32'(STAT_OFS), 32'h1 << ST_REF_ABORT, "abort flag");
        wr(32'(CTRL_OFS), 32'h1);
        pulse(1'b0, 1'b1, '0);
        check({31'h0, prog_go}, 32'h0, "required axis missing");
        wr(ax(3, W_CFG), 32'h0);
        pulse(1'b0, 1'b1, '0);
        check({31'h0, prog_go}, 32'h1, "axis not required");
        wr(32'(STAT_OFS), 32'h1F);
        $display("test done: referencing and start");
        wr(ax(0, W_HOST), 32'h2);
        settle();
        check({31'h0, halt}, 32'h1, "hw limit halt");
        check({31'h0, irq}, 32'h0, "masked interrupt");
        wr(32'(MASK_OFS), 32'h1);
        settle();
        check({31'h0, irq}, 32'h1, "unmasked interrupt");
        wr(ax(0, W_HOST), 32'hC0);
        settle();
        check({31'h0, halt}, 32'h1, "halt latched");
        check({31'h0, jog_p[0]}, 32'h0, "jog toward limit");
        check({31'h0, jog_m[0]}, 32'h1, "jog away from limit");
        wr(32'(CTRL_OFS), 32'h80);
        wr(32'(STAT_OFS), 32'h1);
        settle();
        check({31'h0, halt}, 32'h0, "halt released");
        check({31'h0, irq}, 32'h0, "interrupt cleared");
        $display("test done: hardware limit");
        wr(ax(0, W_CFG), 32'h29);
        wr(ax(2, W_CFG), 32'h28);
        wr(ax(1, W_SL2P), 32'h3E8);
        wr(ax(1, W_HOST), 32'h88);
        pos <= {LIM_P_RST, LIM_P_RST, 32'h7D0, LIM_P_RST};
        settle();
        check({28'h0, decel}, 32'h7, "software limit stop");
        check({31'h0, prog_int}, 32'h1, "program interrupted");
        rd_chk(32'(STAT_OFS), 32'h1 << ST_SW_LIMIT, "software limit flag");
        $display("test done: software limits");
        pos <= '0;
        settle();
        wr(32'(CTRL_OFS), 32'h82);
        wr(32'(STAT_OFS), 32'h1F);
        tgt[2] <= LIM_P_RST;
        settle();
        check({28'h0, decel}, 32'h0, "stop released");
        pulse(1'b1, 1'b0, '0);
        check({30'h0, blk_go, blk_ref}, 32'h2, "target on limit");
        tgt[2] <= LIM_P_RST + 32'h1;
        pulse(1'b1, 1'b0, '0);
        check({30'h0, blk_go, blk_ref}, 32'h1, "target past limit");
        rd_chk(32'(STAT_OFS), 32'h1 << ST_BLOCK_REF, "block refused flag");
        wr(ax(0, W_WAP), 32'h64);
        pos[0] <= 32'hC8;
        tgt <= {32'h0, 32'h0, 32'h0, 32'hC8};
        pulse(1'b1, 1'b0, '0);
        check({30'h0, blk_go, blk_ref}, 32'h2, "rotary, work area off");
        wr(ax(0, W_CFG), 32'hB);
        pulse(1'b1, 1'b0, '0);
        check({30'h0, blk_go, blk_ref}, 32'h1, "work area plus limit");
        $display("test done: automatic blocks");
        print_verdict();
    end
endmodule : axis_limit_monitor_tb
